// *** rtl/rlc_defines.svh ***
// register indices, field masks and reset values of the receive mask and loop-code block
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH

`define RLC_NUM_PORTS      4'h8
`define RLC_PORT_STRIDE    12'h200
`define RLC_IDX_G4_MASK    9'h0A3
`define RLC_IDX_HDLC_MASK  9'h0A4
`define RLC_IDX_M7_MASK    9'h0A6
`define RLC_IDX_SIG_EN1    9'h0A8
`define RLC_IDX_SIG_EN2    9'h0A9
`define RLC_IDX_SIG_EN3    9'h0AA
`define RLC_IDX_SIG_EN4    9'h0AB
`define RLC_IDX_UP1        9'h0AC
`define RLC_IDX_UP2        9'h0AD
`define RLC_IDX_DN1        9'h0AE
`define RLC_IDX_DN2        9'h0AF
`define RLC_IDX_LIVE       9'h0B0
`define RLC_IDX_G4_STAT    9'h0B8
`define RLC_IDX_HDLC_STAT  9'h0B9
`define RLC_IDX_M7_STAT    9'h0BA
`define RLC_IDX_SA_MASK    9'h0BB
`define RLC_IDX_SUMMARY    9'h0BC

`define RLC_G4_BITS        8'h0F
`define RLC_HDLC_BITS      8'h3F
`define RLC_M7_T1_BITS     8'h3F
`define RLC_M7_E1_BITS     8'h03
`define RLC_T1_CHAN_MASK   32'h00FFFFFF
`define RLC_RESET_BYTE     8'h00

`endif

// *** rtl/rlc_pkg.sv ***
// types shared by the receive mask and loop-code register block
package rlc_pkg;

  // per-port event pulses from the framer, all on CLK_SYS
  typedef struct packed {
    logic [31:0] sig_change;
    logic        one_sec;
    logic        timer;
    logic        multiframe;
    logic [5:0]  hdlc;
    logic [5:0]  t1_link;
    logic        sa6_code;
    logic [7:0]  sa_change;
  } rlc_evt_t;

  // per-port line side: mode, received bit stream and detector setup
  typedef struct packed {
    logic        t1_mode;
    logic        rx_bit;
    logic        rx_valid;
    logic [3:0]  code_len;
    logic [15:0] integ;
    logic [3:0]  live_alarm;
  } rlc_line_t;

  typedef struct packed {
    logic        lock;
    logic [15:0] cnt;
  } rlc_det_t;

  typedef struct packed {
    logic [3:0]  g4_mask;
    logic [5:0]  hdlc_mask;
    logic [7:0]  m7_mask;
    logic [31:0] sig_en;
    logic [7:0]  up1;
    logic [7:0]  up2;
    logic [7:0]  dn1;
    logic [7:0]  dn2;
    logic [7:0]  sa_mask;
    logic [3:0]  g4_stat;
    logic [5:0]  hdlc_stat;
    logic [5:0]  m7_stat;
    logic [15:0] shift;
    rlc_det_t    up;
    rlc_det_t    dn;
    logic        up_det;
    logic        dn_det;
    logic        irq;
  } rlc_port_t;

  typedef struct packed {
    rlc_port_t [7:0] port;
    logic [31:0]     prdata;
    logic            err;
  } rlc_state_t;

endpackage

// *** rtl/rlc_regs.sv ***
// receive interrupt enables, signaling change enables and loop-code registers for eight ports
//
// Summary of operation
// - eight register copies, port n at base index plus n times 200h.
// - a cleared enable blocks its event from the interrupt; all enables reset cleared.
// - fourth mask bits 3..0 enable signaling change, one-second, timer, multiframe.
// - HDLC mask bits 5..0 enable overrun, opening byte, end, start, watermark, not empty.
// - T1 seventh mask enables alarm-CI, AIS-CI, loop carrier, link full, code clear, detect.
// - seventh mask holds T1 layout in T1, only bits 1..0 in E1.
// - E1 seventh mask bit 1 enables the Sa6 codeword interrupt.
// - E1 seventh mask bit 0 enables change of any unmasked spare bit.
// - an enabled channel whose signaling changes sets the signaling change flag.
// - four enable registers map channels 1..32; fourth only in E1; reset zero.
// - writing the first up or down code register restarts that detector.
// - up pattern starts at bit 7 of first register; second used beyond eight bits.
// - down pattern arranged like the up pattern.
// - code registers act only in T1 mode and reset to zero.
// - masked status bits are left out of the interrupt summary.
// - loop up and down detected flags follow a match of the defined pattern.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "rlc_defines.svh"

module rlc_regs (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST_N,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [13:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  input  wire logic [3:0]               PSTRB,
  output      logic [31:0]              PRDATA,
  output      logic                     PREADY,
  output      logic                     PSLVERR,
  input  wire rlc_pkg::rlc_evt_t  [7:0] EVT,
  input  wire rlc_pkg::rlc_line_t [7:0] LINE,
  output      logic [7:0]               IRQ,
  output      logic [7:0]               LOOP_UP,
  output      logic [7:0]               LOOP_DN
);

  rlc_pkg::rlc_state_t s;
  rlc_pkg::rlc_state_t next_s;

  // one bit time of a repeating-code detector; len is pattern length minus one
  function automatic rlc_pkg::rlc_det_t code_step(rlc_pkg::rlc_det_t d, logic [15:0] shift, logic bit_in,
                                                  logic [15:0] pat, logic [3:0] len);
    rlc_pkg::rlc_det_t r;
    logic [15:0]       win;
    logic              hit;
    r   = d;
    win = {shift[14:0], bit_in};
    hit = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (4'(i) <= len && win[4'(len - 4'(i))] != pat[4'(15 - i)]) begin
        hit = 1'b0;
      end
    end
    if (d.lock) begin
      // a repeating code means each bit equals the one a pattern length earlier
      if (bit_in == shift[len]) begin
        if (d.cnt != 16'hFFFF) begin
          r.cnt = d.cnt + 16'h0001;
        end
      end else begin
        r.lock = 1'b0;
        r.cnt  = 16'h0000;
      end
    end else if (hit) begin
      r.lock = 1'b1;
      r.cnt  = 16'h0000;
    end
    return r;
  endfunction

  // read decode, returns error flag above the byte
  function automatic logic [8:0] read_byte(rlc_pkg::rlc_port_t q, logic [8:0] idx, logic [3:0] live);
    logic [8:0] r;
    r = {1'b0, `RLC_RESET_BYTE};
    if (idx == `RLC_IDX_G4_MASK) begin
      r[7:0] = {4'h0, q.g4_mask};
    end else if (idx == `RLC_IDX_HDLC_MASK) begin
      r[7:0] = {2'h0, q.hdlc_mask};
    end else if (idx == `RLC_IDX_M7_MASK) begin
      r[7:0] = q.m7_mask;
    end else if (idx == `RLC_IDX_SIG_EN1) begin
      r[7:0] = q.sig_en[7:0];
    end else if (idx == `RLC_IDX_SIG_EN2) begin
      r[7:0] = q.sig_en[15:8];
    end else if (idx == `RLC_IDX_SIG_EN3) begin
      r[7:0] = q.sig_en[23:16];
    end else if (idx == `RLC_IDX_SIG_EN4) begin
      r[7:0] = q.sig_en[31:24];
    end else if (idx == `RLC_IDX_UP1) begin
      r[7:0] = q.up1;
    end else if (idx == `RLC_IDX_UP2) begin
      r[7:0] = q.up2;
    end else if (idx == `RLC_IDX_DN1) begin
      r[7:0] = q.dn1;
    end else if (idx == `RLC_IDX_DN2) begin
      r[7:0] = q.dn2;
    end else if (idx == `RLC_IDX_LIVE) begin
      r[7:0] = {4'h0, live};
    end else if (idx == `RLC_IDX_G4_STAT) begin
      r[7:0] = {4'h0, q.g4_stat};
    end else if (idx == `RLC_IDX_HDLC_STAT) begin
      r[7:0] = {2'h0, q.hdlc_stat};
    end else if (idx == `RLC_IDX_M7_STAT) begin
      r[7:0] = {2'h0, q.m7_stat};
    end else if (idx == `RLC_IDX_SA_MASK) begin
      r[7:0] = q.sa_mask;
    end else if (idx == `RLC_IDX_SUMMARY) begin
      // masked status stays out of the summary
      r[7:0] = {5'h00, |(q.m7_stat & q.m7_mask[5:0]), |(q.hdlc_stat & q.hdlc_mask),
                |(q.g4_stat & q.g4_mask)};
    end else begin
      r[8] = 1'b1;
    end
    return r;
  endfunction

  always_comb begin
    logic        wr;
    logic [2:0]  pidx;
    logic [8:0]  idx;
    logic [7:0]  wd;
    logic        t1;
    logic        sig_hit;
    logic [3:0]  g4_set;
    logic [5:0]  m7_set;
    logic [3:0]  g4_clr;
    logic [5:0]  hdlc_clr;
    logic [5:0]  m7_clr;
    logic [7:0]  m7_bits;
    logic [8:0]  rd;
    wr       = PSEL && PENABLE && PWRITE && PSTRB[0];
    pidx     = PADDR[13:11];
    idx      = PADDR[10:2];
    wd       = PWDATA[7:0];
    t1       = 1'b0;
    sig_hit  = 1'b0;
    g4_set   = 4'h0;
    m7_set   = 6'h00;
    g4_clr   = 4'h0;
    hdlc_clr = 6'h00;
    m7_clr   = 6'h00;
    m7_bits  = 8'h00;
    rd       = 9'h000;
    next_s   = s;
    for (int p = 0; p < 8; p++) begin
      t1      = LINE[p].t1_mode;
      m7_bits = t1 ? `RLC_M7_T1_BITS : `RLC_M7_E1_BITS;
      // the fourth enable register only counts in E1
      sig_hit = |(EVT[p].sig_change & s.port[p].sig_en & (t1 ? `RLC_T1_CHAN_MASK : 32'hFFFFFFFF));
      g4_set  = {sig_hit, EVT[p].one_sec, EVT[p].timer, EVT[p].multiframe};
      m7_set  = t1 ? EVT[p].t1_link :
                {4'h0, EVT[p].sa6_code, |(EVT[p].sa_change & ~s.port[p].sa_mask)};
      g4_clr   = 4'h0;
      hdlc_clr = 6'h00;
      m7_clr   = 6'h00;
      if (wr && pidx == 3'(p)) begin
        if (idx == `RLC_IDX_G4_MASK) begin
          next_s.port[p].g4_mask = wd[3:0];
        end else if (idx == `RLC_IDX_HDLC_MASK) begin
          next_s.port[p].hdlc_mask = wd[5:0];
        end else if (idx == `RLC_IDX_M7_MASK) begin
          next_s.port[p].m7_mask = wd & m7_bits;
        end else if (idx == `RLC_IDX_SIG_EN1) begin
          next_s.port[p].sig_en[7:0] = wd;
        end else if (idx == `RLC_IDX_SIG_EN2) begin
          next_s.port[p].sig_en[15:8] = wd;
        end else if (idx == `RLC_IDX_SIG_EN3) begin
          next_s.port[p].sig_en[23:16] = wd;
        end else if (idx == `RLC_IDX_SIG_EN4) begin
          next_s.port[p].sig_en[31:24] = wd;
        end else if (idx == `RLC_IDX_UP1) begin
          next_s.port[p].up1 = wd;
        end else if (idx == `RLC_IDX_UP2) begin
          next_s.port[p].up2 = wd;
        end else if (idx == `RLC_IDX_DN1) begin
          next_s.port[p].dn1 = wd;
        end else if (idx == `RLC_IDX_DN2) begin
          next_s.port[p].dn2 = wd;
        end else if (idx == `RLC_IDX_G4_STAT) begin
          g4_clr = wd[3:0];
        end else if (idx == `RLC_IDX_HDLC_STAT) begin
          hdlc_clr = wd[5:0];
        end else if (idx == `RLC_IDX_M7_STAT) begin
          m7_clr = wd[5:0];
        end else if (idx == `RLC_IDX_SA_MASK) begin
          next_s.port[p].sa_mask = wd;
        end
      end
      // an event in the clearing cycle survives the write of one
      next_s.port[p].g4_stat   = (s.port[p].g4_stat & ~g4_clr) | g4_set;
      next_s.port[p].hdlc_stat = (s.port[p].hdlc_stat & ~hdlc_clr) | EVT[p].hdlc;
      next_s.port[p].m7_stat   = (s.port[p].m7_stat & ~m7_clr) | m7_set;
      // detectors run only in T1; a stale E1 lock must not linger
      if (!t1) begin
        next_s.port[p].up = '0;
        next_s.port[p].dn = '0;
      end else if (LINE[p].rx_valid) begin
        next_s.port[p].shift = {s.port[p].shift[14:0], LINE[p].rx_bit};
        next_s.port[p].up = code_step(s.port[p].up, s.port[p].shift, LINE[p].rx_bit,
                                      {s.port[p].up1, s.port[p].up2}, LINE[p].code_len);
        next_s.port[p].dn = code_step(s.port[p].dn, s.port[p].shift, LINE[p].rx_bit,
                                      {s.port[p].dn1, s.port[p].dn2}, LINE[p].code_len);
      end
      if (wr && pidx == 3'(p) && idx == `RLC_IDX_UP1) begin
        next_s.port[p].up = '0;
      end
      if (wr && pidx == 3'(p) && idx == `RLC_IDX_DN1) begin
        next_s.port[p].dn = '0;
      end
      next_s.port[p].up_det = t1 && next_s.port[p].up.lock &&
                              next_s.port[p].up.cnt >= LINE[p].integ;
      next_s.port[p].dn_det = t1 && next_s.port[p].dn.lock &&
                              next_s.port[p].dn.cnt >= LINE[p].integ;
      next_s.port[p].irq = |(next_s.port[p].g4_stat & next_s.port[p].g4_mask) |
                           |(next_s.port[p].hdlc_stat & next_s.port[p].hdlc_mask) |
                           |(next_s.port[p].m7_stat & next_s.port[p].m7_mask[5:0] & m7_bits[5:0]);
    end
    // read data is captured in the setup cycle so PRDATA comes from a flop
    if (PSEL && !PENABLE) begin
      rd            = read_byte(s.port[PADDR[13:11]], PADDR[10:2], LINE[PADDR[13:11]].live_alarm);
      next_s.prdata = {24'h000000, rd[7:0]};
      next_s.err    = rd[8] || (PADDR[1:0] != 2'b00);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && s.err;
  assign PRDATA  = s.prdata;

  always_comb begin
    for (int p = 0; p < 8; p++) begin
      IRQ[p]     = s.port[p].irq;
      LOOP_UP[p] = s.port[p].up_det;
      LOOP_DN[p] = s.port[p].dn_det;
    end
  end

  logic bus_wr;
  assign bus_wr = PSEL && PENABLE && PWRITE && PSTRB[0];

  a_irq_gate_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (s.port[0].g4_mask == 4'h0 && s.port[0].hdlc_mask == 6'h00 && s.port[0].m7_mask == 8'h00) |-> !IRQ[0])
    else $error("masked events raised the port interrupt");
  a_irq_gate_on: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (s.port[0].g4_stat[2] && s.port[0].g4_mask[2]) |-> IRQ[0])
    else $error("enabled latched event did not raise the interrupt");
  a_sig_cos_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (|(EVT[2].sig_change[7:0] & s.port[2].sig_en[7:0])) |=> s.port[2].g4_stat[3])
    else $error("enabled channel change did not set the signaling flag");
  a_sig_ch32_t1: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (LINE[2].t1_mode && !s.port[2].g4_stat[3] && EVT[2].sig_change[23:0] == 24'h000000
     && !(bus_wr && PADDR[13:11] == 3'h2)) |=> !s.port[2].g4_stat[3])
    else $error("channels 25 to 32 set the signaling flag in T1");
  a_hdlc_overrun: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    EVT[5].hdlc[5] |=> s.port[5].hdlc_stat[5])
    else $error("overrun event was lost");
  a_t1_link_full: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (LINE[3].t1_mode && EVT[3].t1_link[2]) |=> s.port[3].m7_stat[2])
    else $error("link full event was lost");
  a_e1_sa6_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!LINE[3].t1_mode && EVT[3].sa6_code) |=> s.port[3].m7_stat[1])
    else $error("Sa6 codeword event was lost");
  a_e1_spare_change: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!LINE[3].t1_mode && |(EVT[3].sa_change & ~s.port[3].sa_mask)) |=> s.port[3].m7_stat[0])
    else $error("unmasked spare bit change was lost");
  a_m7_e1_width: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (bus_wr && !LINE[3].t1_mode && PADDR == 14'h1A98) |=> s.port[3].m7_mask[7:2] == 6'h00)
    else $error("E1 seventh mask stored undefined bits");
  a_port_stride: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (bus_wr && PADDR == 14'h2A90) |=> s.port[5].hdlc_mask == $past(PWDATA[5:0]))
    else $error("port five HDLC mask write missed");
  a_up_restart: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (bus_wr && PADDR == 14'h02B0) |=> (!s.port[0].up.lock && s.port[0].up.cnt == 16'h0000 && !LOOP_UP[0]))
    else $error("loop-up write did not restart integration");
  a_e1_no_loop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !LINE[1].t1_mode |=> !LOOP_UP[1] && !LOOP_DN[1])
    else $error("loop code detected outside T1");

  c_irq_raised: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(IRQ[0]));
  c_loop_up_seen: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(LOOP_UP[0]));
  c_w1c_clear: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    s.port[5].hdlc_stat[0] ##1 !s.port[5].hdlc_stat[0]);

endmodule // rlc_regs

// *** test/tb_top.sv ***
// self-checking bench for the receive mask, signaling enable and loop-code register block
`timescale 1ns/1ps
`include "rlc_defines.svh"

module tb_top;
  logic                     clk_sys;
  logic                     rst_n;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [13:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  rlc_pkg::rlc_evt_t  [7:0] evt;
  rlc_pkg::rlc_line_t [7:0] line;
  logic [7:0]               irq;
  logic [7:0]               loop_up;
  logic [7:0]               loop_dn;
  logic [31:0]              rd;
  logic                     er;
  int                       fail_count;
  int                       check_count;

  rlc_regs dut (
    .CLK_SYS (clk_sys),
    .RST_N   (rst_n),
    .PSEL    (psel),
    .PENABLE (penable),
    .PWRITE  (pwrite),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PSTRB   (pstrb),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr),
    .EVT     (evt),
    .LINE    (line),
    .IRQ     (irq),
    .LOOP_UP (loop_up),
    .LOOP_DN (loop_dn)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; the slave is allowed any number of wait states up to the bound
  task automatic apb(input int p, input logic [8:0] idx, input logic w, input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {p[2:0], idx, 2'b00};
    pwdata  <= {24'h000000, d};
    pstrb   <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // only a wait that never saw pready counts as a hang
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int p, input logic [8:0] idx, input logic [7:0] d);
    apb(p, idx, 1'b1, d, 4'hF);
  endtask

  task automatic rdchk(input int p, input logic [8:0] idx, input logic [7:0] d, input logic e);
    apb(p, idx, 1'b0, 8'h00, 4'hF);
    chk(rd, {24'h000000, d});
    chk(32'(er), 32'(e));
  endtask

  // event lines are single-cycle pulses; outputs are looked at once the closing edge has landed
  task automatic pulse(input int p, input int pos);
    @(posedge clk_sys);
    evt[p][pos] <= 1'b1;
    @(posedge clk_sys);
    evt[p][pos] <= 1'b0;
    #1;
  endtask

  task automatic send(input int p, input logic b);
    @(posedge clk_sys);
    line[p].rx_bit   <= b;
    line[p].rx_valid <= 1'b1;
    @(posedge clk_sys);
    line[p].rx_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic irq_case(input int p, input logic [8:0] midx, input logic [8:0] sidx, input int sb, input int b,
                          input int pos);
    logic [7:0] m;
    m = 8'h01 << b;
    wr(p, midx, ~m);
    pulse(p, pos);
    chk(32'(irq[p]), 32'h0);
    rdchk(p, sidx, m, 1'b0);
    rdchk(p, `RLC_IDX_SUMMARY, 8'h00, 1'b0);
    wr(p, midx, m);
    #1 chk(32'(irq[p]), 32'h1);
    rdchk(p, `RLC_IDX_SUMMARY, 8'h01 << sb, 1'b0);
    wr(p, sidx, m);
    #1 chk(32'(irq[p]), 32'h0);
    rdchk(p, sidx, 8'h00, 1'b0);
  endtask

  initial begin
    fail_count  = 0;
    check_count = 0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = '0;
    evt     = '0;
    line    = '0;
    for (int p = 0; p < 8; p++) begin
      line[p].t1_mode = 1'b1;
    end
    line[0].integ      = 16'h0002;
    line[1].code_len   = 4'h2;
    line[4].live_alarm = 4'hA;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({8'h00, irq, loop_up, loop_dn}, 32'h0);
    // holes at 0A5 and 0A7 must answer with an error
    for (int i = 'h0A3; i <= 'h0AF; i++) begin
      rdchk(0, i[8:0], 8'h00, (i == 'h0A5 || i == 'h0A7));
      rdchk(7, i[8:0], 8'h00, (i == 'h0A5 || i == 'h0A7));
    end
    wr(0, 9'h0A5, 8'hFF);
    chk(32'(er), 32'h1);
    rdchk(0, 9'h0A5, 8'h00, 1'b1);
    for (int p = 0; p < 8; p++) begin
      wr(p, `RLC_IDX_UP2, 8'(8'h11 * p + 5));
    end
    for (int p = 0; p < 8; p++) begin
      rdchk(p, `RLC_IDX_UP2, 8'(8'h11 * p + 5), 1'b0);
    end
    apb(0, `RLC_IDX_UP2, 1'b1, 8'hAA, 4'h0);
    rdchk(0, `RLC_IDX_UP2, 8'h05, 1'b0);
    rdchk(4, `RLC_IDX_LIVE, 8'h0A, 1'b0);
    wr(4, `RLC_IDX_LIVE, 8'hFF);
    rdchk(4, `RLC_IDX_LIVE, 8'h0A, 1'b0);
    for (int b = 0; b < 3; b++) begin
      irq_case(0, `RLC_IDX_G4_MASK, `RLC_IDX_G4_STAT, 0, b, 21 + b);
    end
    for (int b = 0; b < 6; b++) begin
      irq_case(5, `RLC_IDX_HDLC_MASK, `RLC_IDX_HDLC_STAT, 1, b, 15 + b);
    end
    wr(2, `RLC_IDX_SIG_EN1, 8'h01);
    irq_case(2, `RLC_IDX_G4_MASK, `RLC_IDX_G4_STAT, 0, 3, 24);
    pulse(2, 25);
    rdchk(2, `RLC_IDX_G4_STAT, 8'h00, 1'b0);
    wr(2, `RLC_IDX_SIG_EN4, 8'h01);
    pulse(2, 48);
    rdchk(2, `RLC_IDX_G4_STAT, 8'h00, 1'b0);
    @(posedge clk_sys);
    line[2].t1_mode <= 1'b0;
    pulse(2, 48);
    rdchk(2, `RLC_IDX_G4_STAT, 8'h08, 1'b0);
    wr(3, `RLC_IDX_M7_MASK, 8'hFF);
    rdchk(3, `RLC_IDX_M7_MASK, 8'h3F, 1'b0);
    for (int b = 0; b < 6; b++) begin
      irq_case(3, `RLC_IDX_M7_MASK, `RLC_IDX_M7_STAT, 2, b, 9 + b);
    end
    @(posedge clk_sys);
    line[3].t1_mode <= 1'b0;
    wr(3, `RLC_IDX_M7_MASK, 8'hFF);
    rdchk(3, `RLC_IDX_M7_MASK, 8'h03, 1'b0);
    irq_case(3, `RLC_IDX_M7_MASK, `RLC_IDX_M7_STAT, 2, 1, 8);
    wr(3, `RLC_IDX_SA_MASK, 8'h01);
    pulse(3, 0);
    rdchk(3, `RLC_IDX_M7_STAT, 8'h00, 1'b0);
    irq_case(3, `RLC_IDX_M7_MASK, `RLC_IDX_M7_STAT, 2, 0, 1);
    pulse(3, 9);
    rdchk(3, `RLC_IDX_M7_STAT, 8'h00, 1'b0);
    // one-bit code of ones with an integration of two further bits
    wr(0, `RLC_IDX_UP1, 8'h80);
    send(0, 1'b1);
    send(0, 1'b1);
    chk(32'(loop_up[0]), 32'h0);
    send(0, 1'b1);
    chk(32'(loop_up[0]), 32'h1);
    wr(0, `RLC_IDX_UP1, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(loop_up[0]), 32'h0);
    // three-bit code 101; the low bits and the second register are don't-cares
    wr(1, `RLC_IDX_DN1, 8'hBF);
    wr(1, `RLC_IDX_DN2, 8'h5A);
    send(1, 1'b1);
    send(1, 1'b0);
    chk(32'(loop_dn[1]), 32'h0);
    send(1, 1'b1);
    chk({loop_up[1], loop_dn[1]}, 32'h1);
    @(posedge clk_sys);
    line[1].t1_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(loop_dn[1]), 32'h0);
    test_done();
  end
endmodule // tb_top
